// [logic/dir_pkg.sv]
// package: constants and carriers for the drive input routing block
package dir_pkg;
   // ----------------------------------------------------------------
   // configuration values
   // ----------------------------------------------------------------
   localparam logic [7:0] DIFF_SUBINDEX       = 8'h07;
   localparam logic       DIFF_SELECT_VALUE   = 1'h1;
   localparam logic       ALT_ENABLE_RESET    = 1'h1;
   localparam logic       DIFF_SELECT_RESET   = 1'h0;
   localparam logic [5:0] LEVEL_SEL_RESET     = 6'h00;
   localparam logic       ANALOG_RANGE_RESET  = 1'h0;
   localparam int         ADC_BITS            = 10;
   localparam int         NUM_INPUTS          = 6;
   localparam logic [3:0] ROTARY_OFF          = 4'h0;
   localparam logic [3:0] ROTARY_CLKDIR       = 4'h1;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ          = 10_000_000;
   localparam int MAX_TOGGLE_HZ   = 1_000_000;
   localparam int MIN_TOGGLE_CYC  = CLK_HZ / MAX_TOGGLE_HZ;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      DIR_ST_CONFIG,
      DIR_ST_ROTARY,
      DIR_ST_PROGRAM,
      DIR_ST_RUN
   } dir_phase_t;

   typedef struct packed {
      logic release_n;
      logic direction;
      logic step_clk;
   } dir_motion_t;

   typedef struct packed {
      dir_phase_t  phase;
      logic        diff_select;
      logic        alt_enable;
      logic        clkdir_mode;
      logic [3:0]  rotary_mode;
      logic [5:0]  level_sel;
      logic        analog_range;
      logic [5:0]  gp_inputs;
      dir_motion_t motion;
      logic        motion_valid;
      logic [9:0]  analog_value;
      logic        program_start;
   } dir_state_t;
endpackage : dir_pkg

// [logic/dir_routing.sv]
// module: drive input routing for the io connector
`timescale 1ns/1ns
`default_nettype none
module dir_routing (
   input  wire logic              i_sys_clk,
   input  wire logic              i_rst_n,
   input  wire logic [5:0]        i_pins,
   input  wire logic [9:0]        i_adc_sample,
   input  wire logic              i_cfg_done,
   input  wire logic              i_cfg_write,
   input  wire logic [7:0]        i_cfg_subindex,
   input  wire logic              i_cfg_diff_value,
   input  wire logic              i_alt_enable_write,
   input  wire logic              i_alt_enable_value,
   input  wire logic              i_factory_default,
   input  wire logic [5:0]        i_level_sel,
   input  wire logic              i_analog_range,
   input  wire logic [3:0]        i_mode_rotary_selector,
   output logic [5:0]             o_gp_inputs,
   output dir_pkg::dir_motion_t   o_motion,
   output logic                   o_motion_valid,
   output logic [5:0]             o_level_sel,
   output logic                   o_analog_range,
   output logic [9:0]             o_analog_value,
   output logic                   o_diff_select,
   output logic                   o_alt_enable,
   output logic                   o_clkdir_mode,
   output logic                   o_program_start
);
   dir_pkg::dir_state_t st;
   dir_pkg::dir_state_t next_st;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // differential pair level: positive leg high and negative leg low
   function automatic logic diff_level(input logic neg, input logic pos);
      diff_level = pos & ~neg;
   endfunction : diff_level

   logic [2:0] pair;
   assign pair[0] = diff_level(i_pins[0], i_pins[1]);
   assign pair[1] = diff_level(i_pins[2], i_pins[3]);
   assign pair[2] = diff_level(i_pins[4], i_pins[5]);

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st               = st;
      next_st.program_start = 1'b0;
      if (i_cfg_write && i_cfg_subindex == dir_pkg::DIFF_SUBINDEX) begin
         next_st.diff_select = (i_cfg_diff_value == dir_pkg::DIFF_SELECT_VALUE);
      end
      if (i_factory_default) begin
         next_st.alt_enable = dir_pkg::ALT_ENABLE_RESET;
      end else if (i_alt_enable_write) begin
         next_st.alt_enable = i_alt_enable_value;
      end
      next_st.level_sel    = i_level_sel;
      next_st.analog_range = i_analog_range;
      next_st.analog_value = i_adc_sample;
      case (st.phase)
         dir_pkg::DIR_ST_CONFIG: begin
            if (i_cfg_done) begin
               next_st.phase = dir_pkg::DIR_ST_ROTARY;
            end
         end
         dir_pkg::DIR_ST_ROTARY: begin
            next_st.rotary_mode = i_mode_rotary_selector;
            next_st.clkdir_mode = (i_mode_rotary_selector == dir_pkg::ROTARY_CLKDIR);
            next_st.phase       = dir_pkg::DIR_ST_PROGRAM;
         end
         dir_pkg::DIR_ST_PROGRAM: begin
            next_st.program_start = 1'b1;
            next_st.phase         = dir_pkg::DIR_ST_RUN;
         end
         dir_pkg::DIR_ST_RUN: begin
            next_st.phase = dir_pkg::DIR_ST_RUN;
         end
         default: begin
            next_st.phase = dir_pkg::DIR_ST_CONFIG;
         end
      endcase
      // routing of pins to functions
      next_st.motion       = '0;
      next_st.motion_valid = 1'b0;
      if (st.diff_select) begin
         next_st.gp_inputs = {3'h0, pair};
      end else begin
         next_st.gp_inputs = i_pins;
      end
      if (st.alt_enable) begin
         next_st.motion_valid = 1'b1;
         if (st.diff_select) begin
            next_st.motion.release_n = pair[0];
            next_st.motion.direction = pair[1];
            next_st.motion.step_clk  = pair[2];
            next_st.gp_inputs        = 6'h00;
         end else begin
            next_st.motion.release_n = i_pins[0];
            next_st.motion.direction = i_pins[1];
            next_st.motion.step_clk  = i_pins[2];
            next_st.gp_inputs        = {i_pins[5:3], 3'h0};
         end
      end else if (st.clkdir_mode) begin
         next_st.motion_valid = 1'b1;
         if (st.diff_select) begin
            next_st.motion.direction = pair[1];
            next_st.motion.step_clk  = pair[2];
         end else begin
            next_st.motion.direction = i_pins[1];
            next_st.motion.step_clk  = i_pins[2];
         end
      end
      if (st.phase != dir_pkg::DIR_ST_RUN) begin
         next_st.motion_valid = 1'b0;
         next_st.motion       = '0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         st              <= '0;
         st.phase        <= dir_pkg::DIR_ST_CONFIG;
         st.diff_select  <= dir_pkg::DIFF_SELECT_RESET;
         st.alt_enable   <= dir_pkg::ALT_ENABLE_RESET;
         st.level_sel    <= dir_pkg::LEVEL_SEL_RESET;
         st.analog_range <= dir_pkg::ANALOG_RANGE_RESET;
         st.rotary_mode  <= dir_pkg::ROTARY_OFF;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign o_gp_inputs     = st.gp_inputs;
   assign o_motion        = st.motion;
   assign o_motion_valid  = st.motion_valid;
   assign o_level_sel     = st.level_sel;
   assign o_analog_range  = st.analog_range;
   assign o_analog_value  = st.analog_value;
   assign o_diff_select   = st.diff_select;
   assign o_alt_enable    = st.alt_enable;
   assign o_clkdir_mode   = st.clkdir_mode;
   assign o_program_start = st.program_start;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_diff_cfg;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_cfg_write && i_cfg_subindex == dir_pkg::DIFF_SUBINDEX && i_cfg_diff_value)
         |=> o_diff_select;
   endproperty
   a_diff_cfg: assert property (p_diff_cfg) else $error("diff select not taken");

   property p_diff_refused;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_cfg_write && i_cfg_subindex != dir_pkg::DIFF_SUBINDEX)
         |=> (o_diff_select == $past(o_diff_select));
   endproperty
   a_diff_refused: assert property (p_diff_refused) else $error("foreign entry moved diff");

   property p_alt_write;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_alt_enable_write && !i_factory_default) |=> (o_alt_enable == $past(i_alt_enable_value));
   endproperty
   a_alt_write: assert property (p_alt_write) else $error("alt enable not stored");

   property p_factory;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      i_factory_default |=> o_alt_enable;
   endproperty
   a_factory: assert property (p_factory) else $error("factory default lost alt");

   property p_se_clkdir;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (st.phase == dir_pkg::DIR_ST_RUN && st.clkdir_mode && !st.alt_enable && !st.diff_select)
         |=> (o_motion.direction == $past(i_pins[1]) && o_motion.step_clk == $past(i_pins[2]));
   endproperty
   a_se_clkdir: assert property (p_se_clkdir) else $error("clock-direction routing wrong");

   property p_diff_pair;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (st.phase == dir_pkg::DIR_ST_RUN && st.alt_enable && st.diff_select)
         |=> (o_motion.step_clk == ($past(i_pins[5]) & ~$past(i_pins[4])));
   endproperty
   a_diff_pair: assert property (p_diff_pair) else $error("pair three wrong");

   property p_alt_diff_legs;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (st.phase == dir_pkg::DIR_ST_RUN && st.alt_enable && st.diff_select)
         |=> (o_motion.release_n == ($past(i_pins[1]) & ~$past(i_pins[0]))
              && o_motion.direction == ($past(i_pins[3]) & ~$past(i_pins[2])));
   endproperty
   a_alt_diff_legs: assert property (p_alt_diff_legs) else $error("pair one or two wrong");

   property p_analog;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      // reset is synchronous, so the first edge that samples i_rst_n high already loads next_st and the attempt it starts holds
      i_rst_n |=> (o_analog_value == $past(i_adc_sample) && o_analog_range == $past(i_analog_range));
   endproperty
   a_analog: assert property (p_analog) else $error("analog path wrong");

   property p_order;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (st.phase == dir_pkg::DIR_ST_CONFIG && i_cfg_done) |=> ##2 o_program_start;
   endproperty
   a_order: assert property (p_order) else $error("start order wrong");

   property p_plain;
      @(posedge i_sys_clk) disable iff (!i_rst_n)
      (!st.alt_enable && !st.clkdir_mode && !st.diff_select)
         |=> (!o_motion_valid && o_gp_inputs == $past(i_pins));
   endproperty
   a_plain: assert property (p_plain) else $error("plain inputs drove motion");
endmodule : dir_routing
`default_nettype wire

// [test/dir_pin_source.sv]
// partner model: external signal source driving the six connector inputs
`timescale 1ns/1ns
`default_nettype none
module dir_pin_source (
   input  wire logic       i_sys_clk,
   input  wire logic [5:0] i_want,
   output logic [5:0]      o_pins
);
   logic [5:0] level = 6'h00;
   int         gap   = 0;
   assign o_pins = level;
   // changes spaced at least eleven clocks apart keep every input at or below 1 MHz
   always @(posedge i_sys_clk) begin
      if (i_want !== level && gap >= dir_pkg::MIN_TOGGLE_CYC) begin
         level <= i_want;
         gap   <= 0;
      end else begin
         gap <= gap + 1;
      end
   end
endmodule : dir_pin_source
`default_nettype wire

// [test/drive_input_routing_bench.sv]
// testbench: routing, config and startup order of the input router
`timescale 1ns/1ns
`default_nettype none
module drive_input_routing_bench;
   logic clk, rst_n, done, cw, dv, aw, av, fd, rng, mv, ro, ds, ae, cd, ps;
   logic [5:0] pins, want, lvl, gp, lo;
   logic [9:0] adc, aout;
   logic [7:0] sub;
   logic [3:0] rot;
   dir_pkg::dir_motion_t mo;
   int failures = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [5:0] pat [3] = '{6'h2D, 6'h12, 6'h38};
   dir_pin_source i_src (.i_sys_clk(clk), .i_want(want), .o_pins(pins));
   dir_routing i_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_pins(pins), .i_adc_sample(adc),
      .i_cfg_done(done), .i_cfg_write(cw), .i_cfg_subindex(sub), .i_cfg_diff_value(dv),
      .i_alt_enable_write(aw), .i_alt_enable_value(av), .i_factory_default(fd),
      .i_level_sel(lvl), .i_analog_range(rng), .i_mode_rotary_selector(rot),
      .o_gp_inputs(gp), .o_motion(mo), .o_motion_valid(mv), .o_level_sel(lo),
      .o_analog_range(ro), .o_analog_value(aout), .o_diff_select(ds), .o_alt_enable(ae),
      .o_clkdir_mode(cd), .o_program_start(ps));
   initial begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles >= 4000) begin
         failures++;
         tally_and_finish();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic show(input logic [5:0] p);
      @(posedge clk) want <= p;
      tick(14);
   endtask : show
   task automatic alt_set(input logic v, input logic f);
      @(posedge clk) begin aw <= 1'h1; av <= v; fd <= f; end
      @(posedge clk) begin aw <= 1'h0; fd <= 1'h0; end
      tick(3);
   endtask : alt_set
   task automatic boot(input logic [3:0] r);
      int n;
      n = 0;
      @(posedge clk) begin rst_n <= 1'h0; rot <= r; end
      repeat (12) @(posedge clk);
      rst_n <= 1'h1;
      tick(1);
      chk("alt_enable", 10'h001, 10'(ae));
      chk("diff_select", 10'h000, 10'(ds));
      @(posedge clk) done <= 1'h1;
      @(posedge clk) done <= 1'h0;
      // counted from the edge that takes done: rotary, program, then the start pulse
      do begin tick(1); n++; end while (ps !== 1'h1 && n < 20);
      chk("start_delay", 10'(2), 10'(n));
      tick(1);
      chk("start_pulse", 10'h000, 10'(ps));
      chk("clkdir_mode", 10'(r == dir_pkg::ROTARY_CLKDIR), 10'(cd));
      $display("test boot done");
   endtask : boot
   task automatic t_alt_single();
      foreach (pat[i]) begin
         show(pat[i]);
         chk("motion", 10'({pat[i][0], pat[i][1], pat[i][2]}), 10'(mo));
         chk("gp", 10'({pat[i][5:3], 3'h0}), 10'(gp));
         chk("valid", 10'h001, 10'(mv));
      end
      alt_set(1'h0, 1'h1);
      chk("alt_factory", 10'h001, 10'(ae));
      $display("test alt_single done");
   endtask : t_alt_single
   task automatic t_clkdir_single();
      alt_set(1'h0, 1'h0);
      chk("alt_off", 10'h000, 10'(ae));
      foreach (pat[i]) begin
         show(pat[i]);
         chk("dir_clk", 10'({pat[i][1], pat[i][2]}), 10'({mo.direction, mo.step_clk}));
         chk("gp_clkdir", 10'(pat[i]), 10'(gp));
         chk("valid", 10'h001, 10'(mv));
      end
      $display("test clkdir_single done");
   endtask : t_clkdir_single
   task automatic t_diff();
      logic [2:0] pr;
      @(posedge clk) begin cw <= 1'h1; sub <= 8'h06; dv <= 1'h1; end
      @(posedge clk) cw <= 1'h0;
      tick(3);
      chk("diff_refused", 10'h000, 10'(ds));
      @(posedge clk) begin cw <= 1'h1; sub <= dir_pkg::DIFF_SUBINDEX; end
      @(posedge clk) cw <= 1'h0;
      tick(3);
      chk("diff_select", 10'h001, 10'(ds));
      foreach (pat[i]) begin
         show(pat[i]);
         // pair level is the positive leg high with the negative leg low
         pr = {pat[i][5] & ~pat[i][4], pat[i][3] & ~pat[i][2], pat[i][1] & ~pat[i][0]};
         chk("pairs", 10'({pr[1], pr[2]}), 10'({mo.direction, mo.step_clk}));
         chk("gp_pairs", 10'(pr), 10'(gp));
      end
      alt_set(1'h1, 1'h0);
      foreach (pat[i]) begin
         show(pat[i]);
         pr = {pat[i][5] & ~pat[i][4], pat[i][3] & ~pat[i][2], pat[i][1] & ~pat[i][0]};
         chk("alt_pairs", 10'({pr[0], pr[1], pr[2]}), 10'(mo));
         chk("alt_gp", 10'h000, 10'(gp));
         chk("alt_valid", 10'h001, 10'(mv));
      end
      $display("test diff done");
   endtask : t_diff
   task automatic t_general();
      alt_set(1'h0, 1'h0);
      foreach (pat[i]) begin
         show(pat[i]);
         chk("gp_plain", 10'(pat[i]), 10'(gp));
         chk("no_motion", 10'h000, {mv, 6'h00, mo});
      end
      @(posedge clk) begin lvl <= 6'h2A; rng <= 1'h1; adc <= 10'h3A5; end
      tick(3);
      chk("level", 10'h02A, 10'(lo));
      chk("range", 10'h001, 10'(ro));
      chk("analog", 10'h3A5, aout);
      $display("test general done");
   endtask : t_general
   task automatic tally_and_finish();
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish
   initial begin
      {rst_n, done, cw, dv, aw, av, fd, rng} = 8'h00;
      {want, lvl, adc, sub, rot} = 34'h0;
      boot(dir_pkg::ROTARY_CLKDIR);
      t_alt_single();
      t_clkdir_single();
      t_diff();
      boot(dir_pkg::ROTARY_OFF);
      t_general();
      tally_and_finish();
   end
endmodule : drive_input_routing_bench
`default_nettype wire
